// *** core/serial_link_rx_capture.sv ***
`timescale 1ns/100ps
module serial_link_rx_capture #(
  parameter int         TIMEOUT_CYC = link_rx_pkg::TIMEOUT_CYCLES,  // timeout
  parameter logic [7:0] DONE_CHAR   = 8'h1B  // transfer done code
) (
  input  wire logic                 mclk,            // system clock
  input  wire logic                 rst,             // master reset
  input  wire logic                 csrResetPulse,   // register reset
  input  wire logic                 reframeCmdPulse, // enable_a command
  input  wire logic                 selfTestStart,   // test start
  input  wire logic                 initRequest,     // init pin
  input  wire logic                 rxClk,           // byte clock
  input  wire logic                 rdyN,            // ready strobe
  input  wire logic [7:0]           rxData,          // receiver byte
  input  wire logic                 specialChar,     // special flag
  input  wire logic                 violation,       // violation flag
  input  wire logic                 enableA,         // count enable
  output link_rx_pkg::ram_wr_t      ramWrite,        // ram write port
  output logic                      reframeRequest,  // to receiver
  output logic                      selfTestEnN,     // to receiver
  output logic                      initPulse,       // init out
  output link_rx_pkg::status_t      status           // flags, mclk
);
  import link_rx_pkg::*;

  localparam logic [15:0] ToutLast = 16'(TIMEOUT_CYC - 1);  // last count

  // ==========================================================
  // declarations
  logic [2:0]        tog_r;         // command toggles, mclk
  logic [3:0]        inSync;        // init and toggles, rx
  logic [2:0]        togPrev_r;     // toggle history
  logic              rxRst;         // reset in rx domain
  logic              csrEv;         // register reset event
  logic              stEv;          // test start event
  logic              refEv;         // enable_a event
  logic              rdyPrevLow_r;  // strobe was low
  logic              rdyRise;       // strobe rising edge
  logic              rdyLow;        // strobe low now
  logic              startChar;     // start seen
  logic              endChar;       // end seen
  logic              doneChar;      // done seen
  logic              startPend_r;   // start awaiting edge
  logic              stream_r;      // stream active
  ram_wr_t           ramOut_r;      // ram outputs
  logic [ADDR_W-1:0] addr_r;        // write address
  logic              wrEn;          // write this cycle
  logic              ovf_r;         // overflow flag
  logic [15:0]       toutCnt_r;     // timeout counter
  logic              counting;      // counter active
  logic              toutHit;       // timeout reached
  logic              timeout_flag_r;        // timeout flag
  logic              streamTout_r;  // stream timeout
  logic              bistTout_r;    // test timeout
  logic              initPrev_r;    // init history
  logic              initLatch_r;   // latched request
  logic              initPulse_r;   // init pulse
  logic              refReq_r;      // enable_a request
  logic [3:0]        refCnt_r;      // four delay flops
  logic              refDone_r;     // enable_a done
  logic              refTout_r;     // enable_a timeout
  bist_state_t       bistSt_r;      // test state
  logic [8:0]        bistCnt_r;     // test byte count
  logic [1:0]        holdCnt_r;     // release delay
  logic              stEn_r;        // test enable, low active
  logic              pass_r;        // test pass
  logic              bistEnd;       // test finishing
  logic              sViol_r;       // stream violation
  logic              bViol_r;       // test violation
  logic              rvsHit;        // violation strobed
  status_t           stRx;          // flags in rx domain

  // ==========================================================
  // byte strobe decode, order 3,4,1,2
  function automatic logic [3:0] wrDecode(input logic [1:0] a);
    case (a)
      2'h0:    wrDecode = 4'h4;
      2'h1:    wrDecode = 4'h8;
      2'h2:    wrDecode = 4'h1;
      default: wrDecode = 4'h2;
    endcase
  endfunction : wrDecode

  // ==========================================================
  // commands: pulses turned to toggles for crossing
  always_ff @(posedge mclk)
  begin
    if (rst)
      tog_r <= 3'h0;
    else
      tog_r <= tog_r ^ {csrResetPulse, selfTestStart, reframeCmdPulse};
  end

  // master reset into link domain
  bit_sync #(.WIDTH(1)) rstSync (
    .clk  (rxClk),
    .rst  (1'b0),
    .din  (rst),
    .dout (rxRst)
  );

  // init pin and toggles into link domain
  bit_sync #(.WIDTH(4)) cmdSync (
    .clk  (rxClk),
    .rst  (rxRst),
    .din  ({initRequest, tog_r}),
    .dout (inSync)
  );

  // toggle edge detection
  always_ff @(posedge rxClk)
  begin
    if (rxRst)
      togPrev_r <= 3'h0;
    else
      togPrev_r <= inSync[2:0];
  end

  assign csrEv = inSync[2] ^ togPrev_r[2];
  assign stEv  = inSync[1] ^ togPrev_r[1];
  assign refEv = inSync[0] ^ togPrev_r[0];

  // ==========================================================
  // character detection
  assign rdyLow    = !rdyN;
  assign rdyRise   = rdyPrevLow_r && !rdyLow;
  assign startChar = rdyLow && specialChar && rxData == K_START_VAL;
  assign endChar   = rdyLow && specialChar && rxData == K_END_VAL;
  assign doneChar  = rdyLow && specialChar && rxData == DONE_CHAR;
  assign rvsHit    = rdyLow && violation;

  // strobe history and pending start
  always_ff @(posedge rxClk)
  begin
    if (rxRst)
    begin
      rdyPrevLow_r <= 1'b0;
      startPend_r  <= 1'b0;
    end
    else
    begin
      rdyPrevLow_r <= rdyLow;
      if (startChar)
        startPend_r <= 1'b1;
      else if (rdyRise || csrEv)
        startPend_r <= 1'b0;
    end
  end

  // stream active flag
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv || endChar || toutHit)
      stream_r <= 1'b0;
    else if (startPend_r && rdyRise)
      stream_r <= 1'b1;
  end

  // ==========================================================
  // ram write path
  assign wrEn = rdyLow && !specialChar && stream_r && enableA
             && stEn_r && !addr_r[OVF_BIT];

  // address counter
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv || initPulse_r)
      addr_r <= ADDR_RST;
    else if (wrEn)
      addr_r <= addr_r + 1'b1;
  end

  // data capture, address and strobes
  always_ff @(posedge rxClk)
  begin
    if (rxRst)
      ramOut_r <= '0;
    else
    begin
      if (rdyLow)
        ramOut_r.data <= rxData;
      ramOut_r.addr   <= addr_r;
      ramOut_r.strobe <= wrEn ? wrDecode(addr_r[1:0]) : 4'h0;
    end
  end

  // overflow flag
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv || initPulse_r)
      ovf_r <= 1'b0;
    else if (addr_r[OVF_BIT])
      ovf_r <= 1'b1;
  end

  // ==========================================================
  // timeout counter
  assign counting = stream_r || bistSt_r == BIST_RUN;
  assign toutHit  = counting && toutCnt_r == ToutLast;

  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv || doneChar || bistEnd)
      toutCnt_r <= 16'h0000;
    else if (counting && toutCnt_r != ToutLast)
      toutCnt_r <= toutCnt_r + 1'b1;
  end

  // timeout flags, set loses to nothing but resets
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv)
    begin
      timeout_flag_r       <= 1'b0;
      streamTout_r <= 1'b0;
      bistTout_r   <= 1'b0;
    end
    else if (toutHit)
    begin
      timeout_flag_r       <= 1'b1;
      streamTout_r <= streamTout_r || stream_r;
      bistTout_r   <= bistTout_r || bistSt_r == BIST_RUN;
    end
  end

  // violation flags
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv)
    begin
      sViol_r <= 1'b0;
      bViol_r <= 1'b0;
    end
    else
    begin
      if (rvsHit && stream_r)
        sViol_r <= 1'b1;
      if (rvsHit && bistSt_r == BIST_RUN)
        bViol_r <= 1'b1;
      else if (stEv)
        bViol_r <= 1'b0;
    end
  end

  // ==========================================================
  // init request latch and pulse
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv)
    begin
      initPrev_r  <= 1'b0;
      initLatch_r <= 1'b0;
      initPulse_r <= 1'b0;
    end
    else
    begin
      initPrev_r  <= inSync[3];
      initLatch_r <= inSync[3] && !initPrev_r;
      initPulse_r <= initLatch_r && (!stream_r || timeout_flag_r);
    end
  end

  // ==========================================================
  // enable_a sequencing
  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv)
    begin
      refReq_r  <= 1'b0;
      refCnt_r  <= 4'h0;
      refDone_r <= 1'b0;
      refTout_r <= 1'b0;
    end
    else if (refEv)
    begin
      refReq_r  <= 1'b1;
      refCnt_r  <= 4'h0;
      refDone_r <= 1'b0;
      refTout_r <= 1'b0;
    end
    else if (refReq_r)
    begin
      if (refCnt_r < ENABLE_A_DELAY)
        refCnt_r <= refCnt_r + 1'b1;
      else if (rdyLow)
      begin
        refDone_r <= 1'b1;
        refReq_r  <= 1'b0;
      end
      else if (refCnt_r == ENABLE_A_LAST)
      begin
        refTout_r <= 1'b1;
        refReq_r  <= 1'b0;
      end
      else
        refCnt_r <= refCnt_r + 1'b1;
    end
  end

  // ==========================================================
  // self test sequencing
  assign bistEnd = bistSt_r == BIST_END && holdCnt_r == BIST_END_DLY;

  always_ff @(posedge rxClk)
  begin
    if (rxRst || csrEv)
    begin
      bistSt_r  <= BIST_IDLE;
      bistCnt_r <= 9'h000;
      holdCnt_r <= 2'h0;
      stEn_r    <= STEN_RST;
      pass_r    <= 1'b0;
    end
    else if (stEv)
    begin
      bistSt_r  <= BIST_RUN;
      bistCnt_r <= 9'h000;
      stEn_r    <= 1'b0;
      pass_r    <= 1'b0;
    end
    else
    begin
      case (bistSt_r)
        BIST_IDLE: ;                             // waiting for start
        BIST_RUN:
          if (toutHit)
          begin
            bistSt_r <= BIST_IDLE;               // abandon on timeout
            stEn_r   <= 1'b1;
          end
          else if (rdyRise)
          begin
            bistCnt_r <= bistCnt_r + 1'b1;
            if (bistCnt_r == BIST_BYTES - 1'b1)
            begin
              bistSt_r  <= BIST_END;
              holdCnt_r <= 2'h1;
              pass_r    <= !bViol_r;
            end
          end
        BIST_END:
          if (bistEnd)
          begin
            stEn_r   <= 1'b1;
            bistSt_r <= BIST_IDLE;
          end
          else
            holdCnt_r <= holdCnt_r + 1'b1;
        default:
          bistSt_r <= BIST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // status back to system domain
  always_comb
  begin
    stRx                 = '0;
    stRx.streamActive    = stream_r;
    stRx.overflow        = ovf_r;
    stRx.reframeDone     = refDone_r;
    stRx.reframeTimeout  = refTout_r;
    stRx.selfTestPass    = pass_r;
    stRx.streamTimeout   = streamTout_r;
    stRx.selfTestTimeout = bistTout_r;
    stRx.streamViol      = sViol_r;
    stRx.selfTestViol    = bViol_r;
    stRx.timeout         = timeout_flag_r;
  end

  bit_sync #(.WIDTH($bits(status_t))) stSync (
    .clk  (mclk),
    .rst  (rst),
    .din  (stRx),
    .dout (status)
  );

  assign ramWrite       = ramOut_r;
  assign reframeRequest = refReq_r;
  assign selfTestEnN    = stEn_r;
  assign initPulse      = initPulse_r;

  // ==========================================================
  // checks
  streamRise_a: assert property (@(posedge rxClk) disable iff (rxRst)
    startPend_r && rdyRise && !csrEv && !toutHit |=> stream_r)
    else $error("stream flag missed start edge");
  streamEnd_a: assert property (@(posedge rxClk) disable iff (rxRst)
    endChar |=> !stream_r)
    else $error("end character left stream active");
  addrStep_a: assert property (@(posedge rxClk) disable iff (rxRst)
    wrEn && !csrEv && !initPulse_r |=> addr_r == $past(addr_r) + 1'b1)
    else $error("address did not advance");
  addrHold_a: assert property (@(posedge rxClk) disable iff (rxRst)
    (!enableA || !stEn_r) && !csrEv && !initPulse_r |=> $stable(addr_r))
    else $error("address moved while disabled");
  ovfStop_a: assert property (@(posedge rxClk) disable iff (rxRst)
    addr_r[OVF_BIT] |=> ramOut_r.strobe == 4'h0)
    else $error("strobe after overflow");
  ovfFlag_a: assert property (@(posedge rxClk) disable iff (rxRst)
    addr_r[OVF_BIT] && !csrEv && !initPulse_r |=> ovf_r)
    else $error("overflow flag not set");
  firstLane_a: assert property (@(posedge rxClk) disable iff (rxRst)
    wrEn && addr_r[1:0] == 2'h0 |=> ramOut_r.strobe == 4'h4)
    else $error("first byte not on third lane");
  initGate_a: assert property (@(posedge rxClk) disable iff (rxRst)
    initPulse_r |-> !$past(stream_r) || $past(timeout_flag_r))
    else $error("init pulse during live transfer");
  initOne_a: assert property (@(posedge rxClk) disable iff (rxRst)
    initLatch_r |=> !initLatch_r)
    else $error("init latch held too long");
  refHold_a: assert property (@(posedge rxClk) disable iff (rxRst)
    refEv ##1 !csrEv [*7] |-> refReq_r && !refDone_r)
    else $error("enable_a finished before delay");
  testRel_a: assert property (@(posedge rxClk) disable iff (rxRst)
    bistSt_r == BIST_RUN ##1 bistSt_r == BIST_END && !csrEv && !stEv
    ##1 !csrEv && !stEv |=> stEn_r)
    else $error("test enable not released");

endmodule : serial_link_rx_capture

// *** core/link_rx_pkg.sv ***
// Operation
// - capture receiver byte when ready strobe low
// - write only strobed bytes, skip null pads
// - start character sets stream active flag
// - end, timeout or resets clear stream flag
// - start is 00 special, end is 08 special
// - stream flag rises on strobe rising edge
// - end character clears flag at its strobe
// - address advances per strobe while streaming
// - count needs enable high, self-test idle
// - top address bit stops strobes and counting
// - top address bit sets overflow flag
// - byte strobes from low bits: 3,4,1,2
// - init pulse only when idle or timed out
// - init request held one byte clock
// - enable_a command sets request to receiver
// - four-flop delay holds off seven cycles
// - later strobe sets done, drops request
// - no completion in eight cycles: timeout flag
// - self-test start drives enable low
// - self-test loop spans 511 bytes
// - enable released two cycles after completion
// - pass flag set at end if clean
// - 16-bit timeout counter with its clears
// - timeout flag after 4 ms, per source
// - violation symbols set stream or test flag
package link_rx_pkg;

  // ==========================================================
  // character codes and widths
  localparam logic [7:0] K_START_VAL = 8'h00;  // start special
  localparam logic [7:0] K_END_VAL   = 8'h08;  // end special
  localparam int         ADDR_W      = 14;     // address width
  localparam int         OVF_BIT     = 13;     // overflow bit

  // ==========================================================
  // timing
  localparam int TIMEOUT_US     = 4000;   // timeout in us
  localparam int BYTE_CLK_KHZ   = 16000;  // byte clock rate
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * BYTE_CLK_KHZ / 1000;
  localparam logic [3:0] ENABLE_A_DELAY = 4'h7;  // hold-off cycles
  localparam logic [3:0] ENABLE_A_WAIT  = 4'h7;  // completion window
  localparam logic [3:0] ENABLE_A_LAST  = ENABLE_A_DELAY + ENABLE_A_WAIT;
  localparam logic [8:0] BIST_BYTES    = 9'h1FF;  // bytes per loop
  localparam logic [1:0] BIST_END_DLY  = 2'h2;    // release delay

  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST  = 14'h0000;  // address
  localparam logic              STEN_RST  = 1'b1;      // test idle

  // ==========================================================
  // types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;    // ram write address
    logic [3:0]        strobe;  // byte write strobes
    logic [7:0]        data;    // captured byte
  } ram_wr_t;

  typedef struct packed {
    logic streamActive;    // stream in progress
    logic overflow;        // address overflow
    logic reframeDone;     // enable_a completed
    logic reframeTimeout;  // enable_a not completed
    logic selfTestPass;    // self test clean
    logic streamTimeout;   // timeout during stream
    logic selfTestTimeout; // timeout during test
    logic streamViol;      // violation during stream
    logic selfTestViol;    // violation during test
    logic timeout;         // any timeout
  } status_t;

  typedef enum logic [2:0] {
    BIST_IDLE = 3'b001,  // no test
    BIST_RUN  = 3'b010,  // loop running
    BIST_END  = 3'b100   // release delay
  } bist_state_t;

endpackage : link_rx_pkg

// *** core/bit_sync.sv ***
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1  // bits synchronised
) (
  input  wire logic             clk,  // destination clock
  input  wire logic             rst,  // sync reset, high
  input  wire logic [WIDTH-1:0] din,  // foreign levels
  output logic      [WIDTH-1:0] dout  // synchronised levels
);

  logic [WIDTH-1:0] stage1_r;  // metastable stage
  logic [WIDTH-1:0] stage2_r;  // stable stage

  // ==========================================================
  // two flip-flop chain, first stage read only by second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
    end
    else
    begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;

endmodule : bit_sync

// *** bench/rx_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// receiver chip model: presents bytes with its ready strobe
module rx_model (
  input  wire logic       rxClk,       // byte clock
  input  wire logic       selfTestEnN, // self test enable, low
  output logic            rdyN,        // ready strobe, low
  output logic [7:0]      rxData,      // decoded byte
  output logic            specialChar, // special flag
  output logic            violation    // violation flag
);
  logic [7:0] bistCnt; // self test byte pattern
  logic       bistBad; // inject a violation at each 80 byte in self test
  // idle levels at time zero
  initial
  begin
    rdyN = 1'b1;
    rxData = 8'h00;
    specialChar = 1'b0;
    violation = 1'b0;
    bistCnt = 8'h00;
    bistBad = 1'b0;
  end
  // one byte with strobe low, lines change after the edge
  task put(input logic [7:0] d, input logic sc, input logic v);
    @(posedge rxClk);
    #1;
    rdyN = 1'b0;
    rxData = d;
    specialChar = sc;
    violation = v;
  endtask : put
  // null pads: strobe high, released lines show the inverse
  task pad(input int n);
    repeat (n)
    begin
      @(posedge rxClk);
      #1;
      rdyN = 1'b1;
      rxData = ~rxData;
      specialChar = ~specialChar;
      violation = 1'b0;
    end
  endtask : pad
  // self test loop started by the enable going low
  always @(negedge selfTestEnN)
  begin
    repeat (511)
    begin
      bistCnt = bistCnt + 8'h01;
      put(bistCnt, 1'b0, bistBad && bistCnt == 8'h80);
      pad(1);
    end
  end
endmodule : rx_model

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
  import link_rx_pkg::*;
  localparam int TOC = 9000;                                   // shortened timeout
  localparam logic [7:0] DONE_CHAR_V = 8'h1B;                  // done code given to design
  localparam logic [3:0] LANES [4] = '{4'h4, 4'h8, 4'h1, 4'h2}; // lane per addr
  logic mclk, rxClk, rst, csrResetPulse, reframeCmdPulse, selfTestStart;
  logic initRequest, enableA, rdyN, specialChar, violation;
  logic [7:0]  rxData;      // receiver byte
  ram_wr_t     ramWrite;    // ram write port
  status_t     status;      // synced flags
  logic        reframeRequest, selfTestEnN, initPulse;
  logic [7:0]  rnd;         // lfsr state
  logic [13:0] expAddr;     // expected write address
  logic [7:0]  expD [$];    // expected written bytes
  ram_wr_t     wq [$];      // observed writes
  int          n_mismatch, compares, nInit, i;

  // ==========================================================
  // design and receiver model
  serial_link_rx_capture #(.TIMEOUT_CYC(TOC), .DONE_CHAR(DONE_CHAR_V)) i_dut (
    .mclk(mclk), .rst(rst), .csrResetPulse(csrResetPulse),
    .reframeCmdPulse(reframeCmdPulse), .selfTestStart(selfTestStart),
    .initRequest(initRequest), .rxClk(rxClk), .rdyN(rdyN), .rxData(rxData),
    .specialChar(specialChar), .violation(violation), .enableA(enableA),
    .ramWrite(ramWrite), .reframeRequest(reframeRequest),
    .selfTestEnN(selfTestEnN), .initPulse(initPulse), .status(status));
  rx_model i_rx (.rxClk(rxClk), .selfTestEnN(selfTestEnN), .rdyN(rdyN),
    .rxData(rxData), .specialChar(specialChar), .violation(violation));

  // ==========================================================
  // clocks, monitor, helpers
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    rxClk = 1'b0;
    #1.7;
    forever #3 rxClk = ~rxClk;
  end
  // one-cycle outputs are caught mid-cycle
  always @(negedge rxClk)
  begin
    if (!rst && ramWrite.strobe !== 4'h0) wq.push_back(ramWrite);
    if (!rst && initPulse === 1'b1) nInit++;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task mwait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : mwait
  // one mclk command pulse: 0 csr reset, 1 enable_a, 2 self test
  // returns about 1 rxClk after the link acts, before enable_a hold-off ends
  task pulse(input int k);
    @(posedge mclk);
    #1;
    csrResetPulse = (k == 0);
    reframeCmdPulse = (k == 1);
    selfTestStart = (k == 2);
    mwait(1);
    {csrResetPulse, reframeCmdPulse, selfTestStart} = 3'b000;
    mwait(1);
  endtask : pulse
  // compare every observed write with the expected lane order
  task chk_writes;
    while (expD.size() > 0)
    begin
      check(wq.size() > 0 ? wq.pop_front() : 26'h0,
            {expAddr, LANES[expAddr[1:0]], expD.pop_front()});
      expAddr++;
    end
    check(wq.size(), 0);
  endtask : chk_writes
  task start_stream;
    i_rx.put(K_START_VAL, 1'b1, 1'b0);
    i_rx.pad(1);
  endtask : start_stream
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {rst, csrResetPulse, reframeCmdPulse, selfTestStart, initRequest} = 5'b10000;
    enableA = 1'b1;
    rnd = 8'h3A;
    expAddr = 14'h0000;
    {n_mismatch, compares, nInit} = '0;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    mwait(4);
    check({status, reframeRequest, selfTestEnN, initPulse, ramWrite},
          {10'h0, 3'b010, 26'h0});
    // stream with random bytes, pads, a done code and a disabled byte
    start_stream();
    for (i = 0; i < 12; i++)
    begin
      rnd = lfsr_next(rnd);
      i_rx.put(rnd, 1'b0, rnd[7]);
      // random enable, changed after the previous byte was sampled
      enableA = rnd[1] || i < 2;
      if (enableA) expD.push_back(rnd);
      if (rnd[0]) i_rx.pad(1);
    end
    i_rx.put(DONE_CHAR_V, 1'b1, 1'b1);
    i_rx.pad(1);
    enableA = 1'b0;
    i_rx.put(8'h5A, 1'b0, 1'b0);
    i_rx.pad(1);
    enableA = 1'b1;
    mwait(3);
    check(status.streamActive, 1'b1);
    i_rx.put(K_END_VAL, 1'b1, 1'b0);
    i_rx.pad(3);
    chk_writes();
    mwait(4);
    check({status.streamActive, status.streamViol}, 2'b01);
    // init refused in a live stream, taken after timeout
    start_stream();
    initRequest = 1'b1;
    i_rx.pad(4);
    initRequest = 1'b0;
    i_rx.pad(4);
    check(nInit, 0);
    i_rx.pad(TOC + 20);
    mwait(4);
    check({status.streamActive, status.streamTimeout, status.timeout}, 3'b011);
    initRequest = 1'b1;
    i_rx.pad(8);
    initRequest = 1'b0;
    check(nInit, 1);
    pulse(0);
    mwait(4);
    check(status.timeout, 1'b0);
    expAddr = 14'h0000;
    // fill the address space until overflow
    start_stream();
    repeat (8192)
    begin
      rnd = lfsr_next(rnd);
      i_rx.put(rnd, 1'b0, 1'b0);
      expD.push_back(rnd);
    end
    i_rx.put(8'hC3, 1'b0, 1'b0);
    i_rx.pad(3);
    chk_writes();
    mwait(4);
    check(status.overflow, 1'b1);
    pulse(0);
    // enable_a answered late, then an early strobe only
    for (int k = 0; k < 2; k++)
    begin
      pulse(1);
      check(reframeRequest, 1'b1);
      i_rx.put(8'hBC, 1'b0, 1'b0);
      i_rx.pad(k == 0 ? 8 : 20);
      if (k == 0) i_rx.put(8'hBC, 1'b0, 1'b0);
      i_rx.pad(3);
      check(reframeRequest, 1'b0);
      mwait(4);
      check(k == 0 ? status.reframeDone : status.reframeTimeout, 1'b1);
    end
    // self test loop, clean and then with two violation symbols
    for (int k = 0; k < 2; k++)
    begin
      i_rx.bistBad = (k == 1);
      pulse(2);
      check(selfTestEnN, 1'b0);
      for (i = 0; i < 1500 && selfTestEnN !== 1'b1; i++) @(posedge rxClk);
      check({i > 1000, selfTestEnN}, 2'b11);
      mwait(4);
      check({status.selfTestPass, status.selfTestViol, status.selfTestTimeout},
            {k == 0, k == 1, 1'b0});
    end
    stop_test();
  end
endmodule : tb
